// ==== logic/cpsl_params.svh ====
// Purpose: constants for the control port serial link
// Assumes: 100 MHz mclk, port reached by 8-bit I/O strobes at address 0xFF
// Notes:   bit delay count steers the bit period in mclk ticks
// How it works
// [R1] writes to port 0xFF drive the serial output from data bit 1
// [R2] port reads return the serial input line level in bit 1
// [R3] port reads return carrier sense inverted in bit 2
// [R4] every character starts with a zero start bit
// [R5] eight data bits follow, least significant bit first
// [R6] one or two idle-level stop bits close each character
// [R7] transmitter sends a ten-bit frame, each bit one bit period
// [R8] bit period comes from delay count, nominally 85000/baud minus 4
// [R9] port writes keep other bits, bit 1 merged after masking with 0xFD
// [R10] idle serial output rests high with port bit 1 set
// [R11] receiver waits for zero start bit, samples eight bits LSB first
// [R12] reception above 1200 baud is not recommended
// [R13] transmission waits until carrier sense signals far printer ready
// [R14] after reset the serial output idles high until a character is queued; a port write clearing bit 1 also drives it low here
`ifndef CPSL_PARAMS_SVH
`define CPSL_PARAMS_SVH
`define CPSL_PORT_ADDR     8'hFF
`define CPSL_TXD_BIT       1
`define CPSL_RXD_BIT       1
`define CPSL_CD_BIT        2
`define CPSL_TXD_MASK      8'hFD
`define CPSL_PORT_RESET    8'h02
`define CPSL_FRAME_BITS    4'hA
`define CPSL_DATA_BITS     4'h8
`define CPSL_DELAY_NUM     85000
`define CPSL_DELAY_SUB     4
`define CPSL_DELAY_RESET   16'h0119
`define CPSL_TICK_NS       10
`define CPSL_TICK_US       1
`define CPSL_TICK_CYCLES   ((`CPSL_TICK_US * 1000) / `CPSL_TICK_NS)
`endif

// ==== logic/cpsl_pkg.sv ====
// Purpose: types for the control port serial link
// Assumes: nothing beyond the params header
// Notes:   states of both shifters
package cpsl_pkg;
    typedef enum logic [1:0] {CPSL_TX_IDLE, CPSL_TX_WAIT, CPSL_TX_SHIFT} cpsl_tx_state_t;
    typedef enum logic [1:0] {CPSL_RX_IDLE, CPSL_RX_HALF, CPSL_RX_BITS, CPSL_RX_STOP} cpsl_rx_state_t;
endpackage : cpsl_pkg

// ==== logic/cpsl_top.sv ====
// Purpose: control port with hardware serial transmitter and receiver
// Assumes: io strobes are one-cycle pulses on mclk, line pins are asynchronous
// Notes:   bit period = bit_delay_count + 4 mclk ticks
`timescale 1ns/1ns
`include "cpsl_params.svh"
module cpsl_top
    import cpsl_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // io port
    input  wire logic [7:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    // bit period setting
    input  wire logic [15:0] bit_delay_count,
    // character stream in
    input  wire logic        send_valid,
    input  wire logic [7:0]  send_character,
    output logic             send_ready,
    // character stream out
    output logic             recv_valid,
    output logic      [7:0]  receive_character,
    input  wire logic        recv_ready,
    // serial pins
    output logic             txd,
    input  wire logic        rxd,
    input  wire logic        carrier_sense_input,
    input  wire logic        wait_for_carrier
);
    typedef struct packed {
        logic [7:0]     port_r;
        logic [7:0]     rdata_r;
        logic [2:0]     rxd_sync_r;
        logic [2:0]     cd_sync_r;
        logic           rxd_r;
        logic           cd_r;
        cpsl_tx_state_t tx_st_r;
        logic [9:0]     tx_sh_r;
        logic [3:0]     tx_cnt_r;
        logic [16:0]    tx_tmr_r;
        logic           txd_r;
        cpsl_rx_state_t rx_st_r;
        logic [7:0]     rx_sh_r;
        logic [3:0]     rx_cnt_r;
        logic [16:0]    rx_tmr_r;
        logic [1:0]     bv_r;
        logic [7:0]     b0_r;
        logic [7:0]     b1_r;
        logic           sready_r;
    } cpsl_state_t;

    cpsl_state_t s_r, s_nxt;

    function automatic logic [16:0] period(input logic [15:0] cnt);
        period = {1'b0, cnt} + 17'(`CPSL_DELAY_SUB); // [R8]
    endfunction : period

    logic port_hit;
    logic tx_start;
    logic rx_push;
    assign port_hit = (io_addr == `CPSL_PORT_ADDR);

    always_comb begin
        s_nxt = s_r;
        rx_push = 1'b0;
        tx_start = 1'b0;
        // three-stage synchronisers, change accepted when stages two and three agree
        s_nxt.rxd_sync_r = {s_r.rxd_sync_r[1:0], rxd};
        s_nxt.cd_sync_r = {s_r.cd_sync_r[1:0], carrier_sense_input};
        if (s_r.rxd_sync_r[2] == s_r.rxd_sync_r[1]) begin
            s_nxt.rxd_r = s_r.rxd_sync_r[2];
        end
        if (s_r.cd_sync_r[2] == s_r.cd_sync_r[1]) begin
            s_nxt.cd_r = s_r.cd_sync_r[2];
        end
        if (port_hit && io_wr) begin
            s_nxt.port_r = (s_r.port_r & `CPSL_TXD_MASK) | (io_wdata & ~`CPSL_TXD_MASK); // [R1] [R9]
        end
        if (port_hit && io_rd) begin
            s_nxt.rdata_r = s_r.port_r & `CPSL_TXD_MASK;
            s_nxt.rdata_r[`CPSL_RXD_BIT] = s_r.rxd_r; // [R2]
            s_nxt.rdata_r[`CPSL_CD_BIT] = ~s_r.cd_r; // [R3]
        end
        // transmitter
        unique case (s_r.tx_st_r)
            CPSL_TX_IDLE: begin
                s_nxt.txd_r = s_r.port_r[`CPSL_TXD_BIT]; // [R10] [R14]
                if (send_valid && s_r.sready_r) begin
                    s_nxt.tx_sh_r = {1'b1, send_character, 1'b0}; // [R4] [R5] [R6]
                    s_nxt.tx_st_r = CPSL_TX_WAIT;
                end
            end
            CPSL_TX_WAIT: begin
                if (!wait_for_carrier || !s_r.cd_r) begin // [R13]
                    tx_start = 1'b1;
                    s_nxt.tx_st_r = CPSL_TX_SHIFT;
                    s_nxt.tx_cnt_r = `CPSL_FRAME_BITS;
                    s_nxt.tx_tmr_r = period(bit_delay_count);
                    s_nxt.txd_r = s_r.tx_sh_r[0];
                    s_nxt.tx_sh_r = {1'b1, s_r.tx_sh_r[9:1]};
                end
            end
            CPSL_TX_SHIFT: begin
                if (s_r.tx_tmr_r > 17'h00001) begin
                    s_nxt.tx_tmr_r = s_r.tx_tmr_r - 17'h00001;
                end else if (s_r.tx_cnt_r == 4'h1) begin
                    s_nxt.tx_st_r = CPSL_TX_IDLE; // [R7]
                    s_nxt.txd_r = s_r.port_r[`CPSL_TXD_BIT];
                end else begin
                    s_nxt.tx_cnt_r = s_r.tx_cnt_r - 4'h1;
                    s_nxt.tx_tmr_r = period(bit_delay_count);
                    s_nxt.txd_r = s_r.tx_sh_r[0]; // [R5]
                    s_nxt.tx_sh_r = {1'b1, s_r.tx_sh_r[9:1]};
                end
            end
            default: s_nxt.tx_st_r = CPSL_TX_IDLE;
        endcase
        s_nxt.sready_r = (s_nxt.tx_st_r == CPSL_TX_IDLE) && !(send_valid && s_r.sready_r);
        // receiver; slow rates recommended, timer counts half a bit period to mid start bit, then whole bit periods
        unique case (s_r.rx_st_r)
            CPSL_RX_IDLE: begin
                if (!s_r.rxd_r) begin // [R11]
                    s_nxt.rx_st_r = CPSL_RX_HALF;
                    s_nxt.rx_tmr_r = period(bit_delay_count) >> 1; // [R12]
                end
            end
            CPSL_RX_HALF: begin
                if (s_r.rx_tmr_r > 17'h00001) begin
                    s_nxt.rx_tmr_r = s_r.rx_tmr_r - 17'h00001;
                end else if (s_r.rxd_r) begin
                    s_nxt.rx_st_r = CPSL_RX_IDLE;
                end else begin
                    s_nxt.rx_st_r = CPSL_RX_BITS;
                    s_nxt.rx_cnt_r = `CPSL_DATA_BITS;
                    s_nxt.rx_tmr_r = period(bit_delay_count);
                end
            end
            CPSL_RX_BITS: begin
                if (s_r.rx_tmr_r > 17'h00001) begin
                    s_nxt.rx_tmr_r = s_r.rx_tmr_r - 17'h00001;
                end else begin
                    s_nxt.rx_sh_r = {s_r.rxd_r, s_r.rx_sh_r[7:1]}; // [R11]
                    s_nxt.rx_tmr_r = period(bit_delay_count);
                    s_nxt.rx_cnt_r = s_r.rx_cnt_r - 4'h1;
                    if (s_r.rx_cnt_r == 4'h1) begin
                        s_nxt.rx_st_r = CPSL_RX_STOP;
                    end
                end
            end
            CPSL_RX_STOP: begin
                if (s_r.rx_tmr_r > 17'h00001) begin
                    s_nxt.rx_tmr_r = s_r.rx_tmr_r - 17'h00001;
                end else begin
                    rx_push = 1'b1;
                    s_nxt.rx_st_r = CPSL_RX_IDLE;
                end
            end
        endcase
        // two-entry buffer: pop head then push at tail
        if (s_r.bv_r[0] && recv_ready) begin
            s_nxt.b0_r = s_r.b1_r;
            s_nxt.bv_r = {1'b0, s_r.bv_r[1]};
        end
        if (rx_push && !s_nxt.bv_r[1]) begin
            if (s_nxt.bv_r[0]) begin
                s_nxt.b1_r = s_r.rx_sh_r;
                s_nxt.bv_r[1] = 1'b1;
            end else begin
                s_nxt.b0_r = s_r.rx_sh_r;
                s_nxt.bv_r[0] = 1'b1;
            end
        end
        if (reset) begin
            s_nxt = '0;
            s_nxt.port_r = `CPSL_PORT_RESET;
            s_nxt.txd_r = 1'b1; // [R14]
            s_nxt.rxd_r = 1'b1;
            s_nxt.rxd_sync_r = 3'h7;
            s_nxt.sready_r = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        s_r <= s_nxt;
    end

    assign io_rdata = s_r.rdata_r;
    assign txd = s_r.txd_r;
    assign send_ready = s_r.sready_r;
    assign recv_valid = s_r.bv_r[0];
    assign receive_character = s_r.b0_r;

    sequence s_start_bit;
        tx_start ##1 !txd;
    endsequence

    a_start_zero: assert property (@(posedge mclk) disable iff (reset) tx_start |-> ##1 !txd) // [R4]
        else $error("start bit not zero");
    a_idle_high: assert property (@(posedge mclk) disable iff (reset)
        (s_r.tx_st_r == CPSL_TX_IDLE && s_r.port_r[1] && $past(s_r.port_r[1])
        && $past(s_r.tx_st_r) == CPSL_TX_IDLE) |-> txd) // [R10]
        else $error("idle line not high");
    a_wr_merge: assert property (@(posedge mclk) disable iff (reset)
        (port_hit && io_wr) |=> s_r.port_r == (($past(s_r.port_r) & 8'hFD) | ($past(io_wdata) & 8'h02))) // [R9]
        else $error("port write merge wrong");
    a_wr_bit1: assert property (@(posedge mclk) disable iff (reset)
        (port_hit && io_wr) |=> s_r.port_r[1] == $past(io_wdata[1])) // [R1]
        else $error("port bit 1 not written");
    a_rd_rxd: assert property (@(posedge mclk) disable iff (reset)
        (port_hit && io_rd) |=> io_rdata[1] == $past(s_r.rxd_r)) // [R2]
        else $error("read bit 1 not rx line");
    a_rd_cd: assert property (@(posedge mclk) disable iff (reset)
        (port_hit && io_rd) |=> io_rdata[2] == !$past(s_r.cd_r)) // [R3]
        else $error("read bit 2 not inverted carrier");
    a_carrier_gate: assert property (@(posedge mclk) disable iff (reset)
        (s_r.tx_st_r == CPSL_TX_WAIT && wait_for_carrier && s_r.cd_r)
        |=> (s_r.tx_st_r == CPSL_TX_WAIT && $stable(txd))) // [R13]
        else $error("sent without printer ready");
    a_tx_frame: assert property (@(posedge mclk) disable iff (reset)
        s_start_bit |-> (s_r.tx_cnt_r == 4'hA)) // [R7]
        else $error("frame count not ten");
    a_tx_period: assert property (@(posedge mclk) disable iff (reset)
        tx_start |=> s_r.tx_tmr_r == {1'b0, $past(bit_delay_count)} + 17'h00004) // [R8]
        else $error("bit period wrong");
    a_rx_stop: assert property (@(posedge mclk) disable iff (reset)
        (s_r.rx_st_r == CPSL_RX_BITS && s_r.rx_cnt_r == 4'h1 && s_r.rx_tmr_r == 17'h00001)
        |=> s_r.rx_st_r == CPSL_RX_STOP) // [R11]
        else $error("eight bits not counted");
endmodule : cpsl_top

// ==== tb/control_port_serial_link_bench.sv ====
// Purpose: self-checking bench for the control port serial link
// Assumes: short bit period through bit_delay_count
// Notes:   expectations kept in bench queues
`timescale 1ns/1ns
module control_port_serial_link_bench;
    import cpsl_pkg::*;
    localparam int DLY = 6;
    localparam int P = DLY + 4;
    logic mclk = 1'b0, reset = 1'b1, io_wr, io_rd, send_valid, send_ready, recv_valid, recv_ready;
    logic txd, rxd, carrier_sense_input, wait_for_carrier;
    logic [7:0] io_addr, io_wdata, io_rdata, send_character, receive_character, rd, b;
    logic [15:0] bit_delay_count;
    logic [7:0] exp_q[$], rexp[$], rx_q[$];
    int err_count = 0, checked = 0, n;
    cpsl_top dut (.mclk, .reset, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .bit_delay_count,
        .send_valid, .send_character, .send_ready, .recv_valid, .receive_character, .recv_ready,
        .txd, .rxd, .carrier_sense_input, .wait_for_carrier);
    cpsl_line_model #(.P(P)) lm (.mclk, .txd, .rxd, .carrier_sense_input);
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (recv_valid === 1'b1 && recv_ready) rx_q.push_back(receive_character);
    task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic port(input logic wr, input logic [7:0] a, input logic [7:0] d);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= wr;
        io_rd <= !wr;
        @(posedge mclk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        repeat (3) @(posedge mclk);
        rd = io_rdata;
    endtask : port
    task automatic send(input logic [7:0] c);
        send_valid <= 1'b1;
        send_character <= c;
        exp_q.push_back(c);
        n = 0;
        do @(posedge mclk); while (send_ready !== 1'b1 && n++ < 2000);
        send_valid <= 1'b0;
        @(posedge mclk);
    endtask : send
    task automatic tx_check(input int cnt);
        n = 0;
        while (lm.got.size() < cnt && n++ < 200 * cnt) @(posedge mclk);
        check("tx count", 10'(lm.got.size()), 10'(cnt));
        while (lm.got.size() > 0) check("tx frame", lm.got.pop_front(), {1'b1, exp_q.pop_front(), 1'b0});
    endtask : tx_check
    task automatic rx_send(input int cnt, input int keep);
        for (int k = 0; k < cnt; k++) begin
            b = 8'($urandom);
            if (k < keep) rexp.push_back(b);
            lm.send_byte(b);
        end
        recv_ready <= 1'b1;
        n = 0;
        while (rx_q.size() < keep && n++ < 300) @(posedge mclk);
        repeat (20) @(posedge mclk);
        check("rx count", 10'(rx_q.size()), 10'(keep));
        while (rx_q.size() > 0) check("rx char", 10'(rx_q.pop_front()), 10'(rexp.pop_front()));
    endtask : rx_send
    initial begin
        {io_wr, io_rd, send_valid, wait_for_carrier} = 4'h0;
        {io_addr, io_wdata, send_character} = 24'h000000;
        recv_ready = 1'b1;
        bit_delay_count = 16'(DLY);
        void'($urandom(52345));
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        check("txd after reset", 10'(txd), 10'h001);
        for (int k = 0; k < 4; k++) begin
            lm.rxd <= !k[1];
            lm.cd_lvl <= k[0];
            repeat (5) @(posedge mclk);
            port(1'b0, 8'hFF, 8'h00);
            check("port read", 10'(rd), 10'({5'h00, !k[0], !k[1], 1'b0}));
        end
        lm.rxd <= 1'b1;
        lm.cd_lvl <= 1'b0;
        repeat (150) @(posedge mclk);
        rx_q.delete();
        $display("port read test done");
        port(1'b1, 8'hFF, 8'hFD);
        check("txd low by port", 10'(txd), 10'h000);
        port(1'b1, 8'h7F, 8'hFF);
        check("txd other address", 10'(txd), 10'h000);
        port(1'b1, 8'hFF, 8'h02);
        check("txd high by port", 10'(txd), 10'h001);
        $display("port write test done");
        lm.listen = 1'b1;
        for (int k = 0; k < 3; k++) send(8'($urandom));
        tx_check(3);
        $display("transmit test done");
        wait_for_carrier <= 1'b1;
        lm.cd_lvl <= 1'b1;
        repeat (5) @(posedge mclk);
        send(8'hA5);
        n = 0;
        repeat (60) @(posedge mclk) n += int'(txd === 1'b0);
        check("txd held for carrier", 10'(n), 10'h000);
        lm.cd_lvl <= 1'b0;
        tx_check(1);
        $display("carrier test done");
        rx_send(3, 3);
        recv_ready <= 1'b0;
        rx_send(3, 2);
        $display("receive test done");
        final_report();
    end
    initial begin
        #200000;
        err_count++;
        final_report();
    end
endmodule : control_port_serial_link_bench

// ==== tb/cpsl_line_model.sv ====
// Purpose: far-end serial terminal for the link
// Assumes: bit period of P mclk cycles
// Notes:   line idles high, frames decoded at mid-bit
`timescale 1ns/1ns
module cpsl_line_model #(parameter int P = 10) (
    // clock
    input  wire logic mclk,
    // serial pins
    input  wire logic txd,
    output logic      rxd,
    output logic      carrier_sense_input
);
    logic [9:0] got[$];
    logic       listen = 1'b0;
    logic       cd_lvl = 1'b0;
    logic [9:0] fr;
    initial rxd = 1'b1;
    assign carrier_sense_input = cd_lvl;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (P) @(posedge mclk);
        end
    endtask : send_byte
    always begin
        @(negedge txd);
        if (listen) begin
            repeat (P / 2) @(posedge mclk);
            for (int i = 0; i < 10; i++) begin
                fr[i] = txd;
                if (i < 9) repeat (P) @(posedge mclk);
            end
            got.push_back(fr);
        end
    end
endmodule : cpsl_line_model
